// ===== hw/ddr_timing_pkg.sv
/*
 Shared constants and types for the DDR3 dynamic termination and write
 leveling link model: cycle counts, field widths and termination states.
 Assumes both ends run on one 100 MHz clock that stands for CK.
*/
package ddr_timing_pkg;

   // ----------------------------------------
   // Clock and widths
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int DQ_WIDTH = 8;
   localparam int LAT_W = 4;
   localparam int WL_W = 5;
   localparam int CNT_W = 6;
   localparam int HIST_DEPTH = 64;
   localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

   // ----------------------------------------
   // Termination timing in clock edges
   // ----------------------------------------
   localparam int ODT_MIN_HIGH_SHORT_CK = 4;
   localparam int ODT_MIN_HIGH_FULL_CK = 6;
   localparam int NOM_TO_WRITE_OFFSET_CK = 2;
   localparam int TERM_OFF_OFFSET_CK = 2;
   localparam int CHOP_RETURN_CK = 4;
   localparam int FULL_RETURN_CK = 6;

   // ----------------------------------------
   // Write leveling timing
   // ----------------------------------------
   localparam int LEVEL_STROBE_ENABLE_WAIT_CK = 25;
   localparam int LEVEL_FIRST_STROBE_WAIT_CK = 40;
   localparam bit FAST_GRADE = 1'b0;
   localparam int FEEDBACK_MAX_SLOW_PS = 7500;
   localparam int FEEDBACK_MAX_FAST_PS = 7000;
   localparam int FEEDBACK_MAX_PS = FAST_GRADE ? FEEDBACK_MAX_FAST_PS : FEEDBACK_MAX_SLOW_PS;
   localparam int LEVEL_FEEDBACK_SKEW_PS = 2000;
   // Longest time: round down, but never below one cycle.
   localparam int LEVEL_FEEDBACK_DELAY_CK =
      (FEEDBACK_MAX_PS / CLK_PERIOD_PS < 1) ? 1 : FEEDBACK_MAX_PS / CLK_PERIOD_PS;
   // Least time before sampling: round up.
   localparam int LEVEL_SAMPLE_WAIT_CK =
      (FEEDBACK_MAX_PS + LEVEL_FEEDBACK_SKEW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LINK_PIPE_CK = 1;

   typedef enum logic [1:0] {
      TERM_OFF,
      TERM_NOM,
      TERM_WRITE
   } term_t;

endpackage : ddr_timing_pkg

// ===== hw/ddr_link_if.sv
/*
 Link between the memory controller end and the DRAM end: termination
 control, write command, write leveling strobe and data feedback.
 Assumes both ends share SYS_CLK_IN; the bench joins the two modports.
*/
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if;
   import ddr_timing_pkg::*;

   logic ck_link;
   logic odt;
   logic wr_cmd;
   logic wr_chop;
   logic [LAT_W-1:0] al;
   logic [LAT_W-1:0] cwl;
   logic dyn_odt_en;
   logic level_mode;
   logic dqs;
   logic dqs_oe;
   logic [DQ_WIDTH-1:0] dq;
   logic dq_oe;

   modport ctrl (
      output ck_link, odt, wr_cmd, wr_chop, al, cwl, dyn_odt_en,
      output level_mode, dqs, dqs_oe,
      input dq, dq_oe
   );

   modport dram (
      input ck_link, odt, wr_cmd, wr_chop, al, cwl, dyn_odt_en,
      input level_mode, dqs, dqs_oe,
      output dq, dq_oe
   );
endinterface : ddr_link_if
`default_nettype wire

// ===== hw/ddr_ctrl_end.sv
/*
 Controller end: drives the link clock level, termination control, write
 commands and the write leveling sequence, and collects the feedback.
 Assumes the DRAM end on the other modport and one shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_end (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   // Link
   ddr_link_if.ctrl LINK,
   // Configuration
   input wire logic [ddr_timing_pkg::LAT_W-1:0] AL_IN,
   input wire logic [ddr_timing_pkg::LAT_W-1:0] CWL_IN,
   input wire logic DYN_ODT_EN_IN,
   // Termination and writes
   input wire logic ODT_REQ_IN,
   input wire logic WRITE_REQ_IN,
   input wire logic WRITE_CHOP_IN,
   output logic WRITE_READY_OUT,
   // Write leveling
   input wire logic LEVEL_START_IN,
   output logic LEVEL_BUSY_OUT,
   output logic LEVEL_DONE_OUT,
   output logic [ddr_timing_pkg::DQ_WIDTH-1:0] LEVEL_RESULT_OUT
);
   import ddr_timing_pkg::*;

   typedef enum {LV_IDLE, LV_ENTER, LV_ARM, LV_WAIT} level_state_t;

   // ----------------------------------------
   // Link configuration and clock level
   // ----------------------------------------
   logic ck_link, dyn_en;
   logic [LAT_W-1:0] al, cwl;
   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ck_link <= 1'b0;
         al <= '0;
         cwl <= '0;
         dyn_en <= 1'b0;
      end else begin
         ck_link <= ~ck_link;
         al <= AL_IN;
         cwl <= CWL_IN;
         dyn_en <= DYN_ODT_EN_IN;
      end
   end

   // ----------------------------------------
   // Writes and termination control
   // ----------------------------------------
   logic odt, wr_cmd, wr_chop, next_odt, next_wr_cmd, next_wr_chop, write_go;
   logic [CNT_W-1:0] hold, next_hold, start;
   level_state_t state, next_state;

   // Writes would corrupt a leveling probe, so they wait for idle.
   assign WRITE_READY_OUT = (state == LV_IDLE);
   assign write_go = WRITE_REQ_IN & WRITE_READY_OUT;

   always_comb begin
      next_wr_cmd = write_go;
      next_wr_chop = write_go ? WRITE_CHOP_IN : wr_chop;
      start = CNT_RESET;
      if (write_go) begin
         start = WRITE_CHOP_IN ? CNT_W'(ODT_MIN_HIGH_SHORT_CK) : CNT_W'(ODT_MIN_HIGH_FULL_CK);
      end else if (ODT_REQ_IN && !odt) begin
         start = CNT_W'(ODT_MIN_HIGH_SHORT_CK);
      end
      if (start > hold) begin
         next_hold = start;
      end else if (hold != CNT_RESET) begin
         next_hold = hold - CNT_W'(1);
      end else begin
         next_hold = hold;
      end
      next_odt = ODT_REQ_IN | (next_hold != CNT_RESET) | write_go;
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         odt <= 1'b0;
         wr_cmd <= 1'b0;
         wr_chop <= 1'b0;
         hold <= CNT_RESET;
      end else begin
         odt <= next_odt;
         wr_cmd <= next_wr_cmd;
         wr_chop <= next_wr_chop;
         hold <= next_hold;
      end
   end

   // ----------------------------------------
   // Write leveling sequence
   // ----------------------------------------
   logic lvl, dqs, dqs_oe, done, next_lvl, next_dqs, next_dqs_oe, next_done;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [DQ_WIDTH-1:0] result, next_result;

   always_comb begin
      next_state = state;
      next_cnt = (cnt == CNT_MAX) ? cnt : cnt + CNT_W'(1);
      next_lvl = lvl;
      next_dqs = dqs;
      next_dqs_oe = dqs_oe;
      next_done = 1'b0;
      next_result = result;
      case (state)
         LV_IDLE: begin
            if (LEVEL_START_IN) begin
               next_state = LV_ENTER;
               next_lvl = 1'b1;
               next_cnt = CNT_RESET;
            end
         end
         LV_ENTER: begin
            if (next_cnt == CNT_W'(LEVEL_STROBE_ENABLE_WAIT_CK)) begin
               next_dqs_oe = 1'b1;
               next_state = LV_ARM;
            end
         end
         LV_ARM: begin
            if (next_cnt == CNT_W'(LEVEL_FIRST_STROBE_WAIT_CK)) begin
               next_dqs = 1'b1;
               next_cnt = CNT_RESET;
               next_state = LV_WAIT;
            end
         end
         LV_WAIT: begin
            // Sample only after the latest feedback plus its spread.
            if (next_cnt == CNT_W'(LINK_PIPE_CK + LEVEL_SAMPLE_WAIT_CK)) begin
               next_result = LINK.dq;
               next_done = 1'b1;
               next_dqs = 1'b0;
               next_dqs_oe = 1'b0;
               next_lvl = 1'b0;
               next_state = LV_IDLE;
            end
         end
         default: begin
            next_state = LV_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state <= LV_IDLE;
         cnt <= CNT_RESET;
         lvl <= 1'b0;
         dqs <= 1'b0;
         dqs_oe <= 1'b0;
         done <= 1'b0;
         result <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         lvl <= next_lvl;
         dqs <= next_dqs;
         dqs_oe <= next_dqs_oe;
         done <= next_done;
         result <= next_result;
      end
   end

   assign LINK.ck_link = ck_link;
   assign LINK.odt = odt;
   assign LINK.wr_cmd = wr_cmd;
   assign LINK.wr_chop = wr_chop;
   assign LINK.al = al;
   assign LINK.cwl = cwl;
   assign LINK.dyn_odt_en = dyn_en;
   assign LINK.level_mode = lvl;
   assign LINK.dqs = dqs;
   assign LINK.dqs_oe = dqs_oe;
   assign LEVEL_BUSY_OUT = (state != LV_IDLE);
   assign LEVEL_DONE_OUT = done;
   assign LEVEL_RESULT_OUT = result;

endmodule : ddr_ctrl_end
`default_nettype wire

// ===== hw/ddr_dram_end.sv
/*
 DRAM end: applies nominal and write termination with dynamic switching
 around writes, answers write leveling strobes with the sampled clock
 level on all data lines, and flags link timing violations.
 Assumes the controller end on the other modport and one shared clock
 whose rising edges stand for CK edges.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Controller holds termination pin high 4+ cycles.
// - Write termination starts write latency minus 2.
// - Chopped write: nominal returns 4 plus off-latency.
// - Full write: nominal returns 6 plus off-latency.
// - Termination change lands 0.3-0.7 cycle after edge.
// - Controller enables strobe at 25, strobes at 40 cycles after entry.
// - Feedback appears within the longest delay; sample after.
// - Feedback lines differ by at most 2 ns.
// - Times convert to cycles, minimum up, maximum down.
// - Cycle limits count real clock edges.
module ddr_dram_end (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   // Link
   ddr_link_if.dram LINK,
   // Termination state
   output var ddr_timing_pkg::term_t TERM_STATE_OUT,
   output logic WRITE_WINDOW_OUT,
   // Write leveling state
   output logic LEVEL_MODE_OUT,
   // Link timing violations, sticky until reset
   output logic ODT_SHORT_OUT,
   output logic STROBE_EARLY_OUT
);
   import ddr_timing_pkg::*;

   // ----------------------------------------
   // Latencies
   // ----------------------------------------
   logic [WL_W-1:0] wl;
   logic [CNT_W-1:0] switch_at, off_lat, chop_end, full_end, end_at;
   logic chop;

   always_comb begin
      wl = {1'b0, LINK.al} + {1'b0, LINK.cwl};
      // Write latency below two is not a legal setting.
      switch_at = CNT_W'(wl) - CNT_W'(NOM_TO_WRITE_OFFSET_CK);
      off_lat = CNT_W'(wl) - CNT_W'(TERM_OFF_OFFSET_CK);
      chop_end = CNT_W'(CHOP_RETURN_CK) + off_lat;
      full_end = CNT_W'(FULL_RETURN_CK) + off_lat;
      end_at = chop ? chop_end : full_end;
   end

   // ----------------------------------------
   // Write termination window
   // ----------------------------------------
   logic busy, wr_term, next_busy, next_chop, next_wr_term;
   logic [CNT_W-1:0] cnt, next_cnt;

   // The counter holds the number of edges since the write edge.
   always_comb begin
      next_busy = busy;
      next_chop = chop;
      next_cnt = cnt;
      next_wr_term = wr_term;
      if (LINK.wr_cmd) begin
         next_busy = 1'b1;
         next_chop = LINK.wr_chop;
         next_cnt = CNT_RESET;
         // With a write latency of two the switch falls on the write edge itself.
         if (switch_at == CNT_RESET) begin
            next_wr_term = 1'b1;
         end
      end else if (busy) begin
         next_cnt = cnt + CNT_W'(1);
         if (next_cnt == switch_at) begin
            next_wr_term = 1'b1;
         end
         if (next_cnt == end_at) begin
            next_wr_term = 1'b0;
            next_busy = 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         busy <= 1'b0;
         chop <= 1'b0;
         cnt <= CNT_RESET;
         wr_term <= 1'b0;
      end else begin
         busy <= next_busy;
         chop <= next_chop;
         cnt <= next_cnt;
         wr_term <= next_wr_term;
      end
   end

   // ----------------------------------------
   // Nominal termination from pin history
   // ----------------------------------------
   // Bit k holds the pin level sampled k edges before the latest edge.
   logic [HIST_DEPTH-1:0] odt_hist, next_odt_hist;
   logic nom_on;

   always_comb begin
      next_odt_hist = {odt_hist[HIST_DEPTH-2:0], LINK.odt};
      nom_on = odt_hist[switch_at];
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         odt_hist <= '0;
      end else begin
         odt_hist <= next_odt_hist;
      end
   end

   // ----------------------------------------
   // Termination output
   // ----------------------------------------
   // Sampling on the falling edge places every change half a cycle after
   // its reference edge, inside the allowed settle window.
   term_t term, next_term;

   always_comb begin
      if (LINK.dyn_odt_en && wr_term) begin
         next_term = TERM_WRITE;
      end else if (nom_on) begin
         next_term = TERM_NOM;
      end else begin
         next_term = TERM_OFF;
      end
   end

   always_ff @(negedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         term <= TERM_OFF;
      end else begin
         term <= next_term;
      end
   end

   // ----------------------------------------
   // Write leveling feedback
   // ----------------------------------------
   logic dqs_prev, strobe_rise, dq_oe, lvl, next_dqs_prev, next_dq_oe, next_lvl;
   logic [DQ_WIDTH-1:0] dq, next_dq;

   assign strobe_rise = LINK.level_mode & LINK.dqs_oe & LINK.dqs & ~dqs_prev;

   // One register feeds every line, so the lines carry no skew and the
   // answer arrives one cycle after the strobe, within the longest delay.
   always_comb begin
      next_dqs_prev = LINK.dqs & LINK.dqs_oe;
      next_lvl = LINK.level_mode;
      next_dq_oe = LINK.level_mode;
      next_dq = dq;
      if (!LINK.level_mode) begin
         next_dq = '0;
      end else if (strobe_rise) begin
         next_dq = {DQ_WIDTH{LINK.ck_link}};
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         dqs_prev <= 1'b0;
         lvl <= 1'b0;
         dq_oe <= 1'b0;
         dq <= '0;
      end else begin
         dqs_prev <= next_dqs_prev;
         lvl <= next_lvl;
         dq_oe <= next_dq_oe;
         dq <= next_dq;
      end
   end

   // ----------------------------------------
   // Link timing watch
   // ----------------------------------------
   // These flags only report; the device keeps working, because a real
   // part cannot refuse a badly timed controller either.
   logic odt_prev, pulse_full, odt_short, strobe_early;
   logic next_odt_prev, next_pulse_full, next_odt_short, next_strobe_early;
   logic [CNT_W-1:0] odt_run, lvl_cnt, next_odt_run, next_lvl_cnt, odt_min;

   always_comb begin
      next_odt_prev = LINK.odt;
      next_odt_short = odt_short;
      next_strobe_early = strobe_early;
      next_pulse_full = pulse_full;
      next_odt_run = odt_run;
      odt_min = pulse_full ? CNT_W'(ODT_MIN_HIGH_FULL_CK) : CNT_W'(ODT_MIN_HIGH_SHORT_CK);
      if (LINK.odt) begin
         next_odt_run = (odt_run == CNT_MAX) ? odt_run : odt_run + CNT_W'(1);
         if (!odt_prev) begin
            next_odt_run = CNT_W'(1);
            next_pulse_full = 1'b0;
         end
         if (LINK.wr_cmd && !LINK.wr_chop) begin
            next_pulse_full = 1'b1;
         end
      end else if (odt_prev && odt_run < odt_min) begin
         next_odt_short = 1'b1;
      end
      next_lvl_cnt = CNT_RESET;
      if (LINK.level_mode) begin
         next_lvl_cnt = (lvl_cnt == CNT_MAX) ? lvl_cnt : lvl_cnt + CNT_W'(1);
      end
      if (LINK.level_mode && LINK.dqs_oe && lvl_cnt < CNT_W'(LEVEL_STROBE_ENABLE_WAIT_CK)) begin
         next_strobe_early = 1'b1;
      end
      if (strobe_rise && lvl_cnt < CNT_W'(LEVEL_FIRST_STROBE_WAIT_CK)) begin
         next_strobe_early = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         odt_prev <= 1'b0;
         pulse_full <= 1'b0;
         odt_short <= 1'b0;
         strobe_early <= 1'b0;
         odt_run <= CNT_RESET;
         lvl_cnt <= CNT_RESET;
      end else begin
         odt_prev <= next_odt_prev;
         pulse_full <= next_pulse_full;
         odt_short <= next_odt_short;
         strobe_early <= next_strobe_early;
         odt_run <= next_odt_run;
         lvl_cnt <= next_lvl_cnt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign LINK.dq = dq;
   assign LINK.dq_oe = dq_oe;
   assign TERM_STATE_OUT = term;
   assign WRITE_WINDOW_OUT = wr_term;
   assign LEVEL_MODE_OUT = lvl;
   assign ODT_SHORT_OUT = odt_short;
   assign STROBE_EARLY_OUT = strobe_early;

endmodule : ddr_dram_end
`default_nettype wire

// ===== sim/ddr_link_sva.sv
/*
 Checker for the link between the controller end and the DRAM end.
 Assumes the bench wires it to the link interface and the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_link_sva (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   // Link signals
   input wire logic ck_link,
   input wire logic odt,
   input wire logic wr_cmd,
   input wire logic wr_chop,
   input wire logic level_mode,
   input wire logic dqs,
   input wire logic dqs_oe,
   input wire logic [ddr_timing_pkg::DQ_WIDTH-1:0] dq,
   input wire logic dq_oe
);
   import ddr_timing_pkg::*;

   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!NRST_IN);

   // ----------------------------------------
   // Leveling mode age, saturating
   // ----------------------------------------
   logic [5:0] lvl_cnt;
   logic [5:0] next_lvl_cnt;

   always_comb begin
      next_lvl_cnt = lvl_cnt;
      if (!level_mode) begin
         next_lvl_cnt = 6'h00;
      end else if (lvl_cnt != 6'h3F) begin
         next_lvl_cnt = lvl_cnt + 6'h01;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         lvl_cnt <= 6'h00;
      end else begin
         lvl_cnt <= next_lvl_cnt;
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_odt_rise;
      $rose(odt) |-> odt [*4];
   endproperty
   a_odt_rise: assert property (p_odt_rise) else $error("odt pulse under four cycles");
   property p_odt_full;
      wr_cmd && !wr_chop |-> odt [*6];
   endproperty
   a_odt_full: assert property (p_odt_full) else $error("odt under six cycles on full write");
   property p_ck_toggle;
      $past(NRST_IN) |-> ck_link != $past(ck_link);
   endproperty
   a_ck_toggle: assert property (p_ck_toggle) else $error("link clock missed an edge");
   property p_enable_wait;
      $rose(dqs_oe) |-> lvl_cnt >= 6'(LEVEL_STROBE_ENABLE_WAIT_CK);
   endproperty
   a_enable_wait: assert property (p_enable_wait) else $error("strobe driven too early");
   property p_first_strobe;
      $rose(dqs && dqs_oe) |-> lvl_cnt >= 6'(LEVEL_FIRST_STROBE_WAIT_CK);
   endproperty
   a_first_strobe: assert property (p_first_strobe) else $error("strobe rose too early");
   property p_feedback;
      $rose(dqs && dqs_oe) |=> dq_oe && dq == {DQ_WIDTH{$past(ck_link)}};
   endproperty
   a_feedback: assert property (p_feedback) else $error("feedback late or wrong");
   property p_feedback_equal;
      dq_oe |-> dq == '0 || dq == '1;
   endproperty
   a_feedback_equal: assert property (p_feedback_equal) else $error("feedback lines differ");
   property p_level_end;
      $rose(dqs && dqs_oe) |-> ##2 $fell(level_mode);
   endproperty
   a_level_end: assert property (p_level_end) else $error("leveling ended off time");
endmodule : ddr_link_sva
`default_nettype wire

// ===== sim/tb.sv
/*
 Bench for both link ends: writes, termination pulses, leveling, reset.
 Assumes one 100 MHz clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ddr_timing_pkg::*;
   logic clk;
   logic nrst;
   logic [3:0] al_in;
   logic [3:0] cwl_in;
   logic dyn_in;
   logic odt_req;
   logic wr_req;
   logic chop_in;
   logic lvl_start;
   logic wr_ready;
   logic lvl_busy;
   logic lvl_done;
   logic [DQ_WIDTH-1:0] lvl_result;
   term_t term;
   logic win;
   logic lvl_mode;
   logic odt_short;
   logic strobe_early;
   int error_cnt;
   int check_count;
   int seed;
   int edge_n;
   logic [31:0] r;

   ddr_link_if link ();
   ddr_ctrl_end u_ddr_ctrl_end (.SYS_CLK_IN(clk), .NRST_IN(nrst), .LINK(link.ctrl), .AL_IN(al_in),
      .CWL_IN(cwl_in), .DYN_ODT_EN_IN(dyn_in), .ODT_REQ_IN(odt_req), .WRITE_REQ_IN(wr_req),
      .WRITE_CHOP_IN(chop_in), .WRITE_READY_OUT(wr_ready), .LEVEL_START_IN(lvl_start),
      .LEVEL_BUSY_OUT(lvl_busy), .LEVEL_DONE_OUT(lvl_done), .LEVEL_RESULT_OUT(lvl_result));
   ddr_dram_end u_ddr_dram_end (.SYS_CLK_IN(clk), .NRST_IN(nrst), .LINK(link.dram), .TERM_STATE_OUT(term),
      .WRITE_WINDOW_OUT(win), .LEVEL_MODE_OUT(lvl_mode), .ODT_SHORT_OUT(odt_short),
      .STROBE_EARLY_OUT(strobe_early));
   ddr_link_sva u_ddr_link_sva (.SYS_CLK_IN(clk), .NRST_IN(nrst), .ck_link(link.ck_link), .odt(link.odt),
      .wr_cmd(link.wr_cmd), .wr_chop(link.wr_chop), .level_mode(link.level_mode), .dqs(link.dqs),
      .dqs_oe(link.dqs_oe), .dq(link.dq), .dq_oe(link.dq_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts edges since reset release; the link clock level follows its parity.
   always @(posedge clk) edge_n <= nrst ? edge_n + 1 : 0;

   // ----------------------------------------
   // Compare and expectation helpers
   // ----------------------------------------
   task automatic chk_bit(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic chk_vec(input string name, input logic [DQ_WIDTH-1:0] exp, input logic [DQ_WIDTH-1:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_vec

   task automatic chk_term(input string name, input term_t exp, input term_t got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_term

   function automatic term_t exp_term(input int t, input int lo, input int hi, input bit wr, input bit dyn);
      if (t < lo || t > hi) begin
         return TERM_OFF;
      end
      return (wr && dyn) ? TERM_WRITE : TERM_NOM;
   endfunction : exp_term

   task automatic report_and_stop();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk_term("reset_term", TERM_OFF, term);
      chk_bit("reset_ready", 1'b1, wr_ready);
      chk_bit("reset_busy", 1'b0, lvl_busy);
      @(posedge clk);
      nrst <= 1'b1;
   endtask : do_reset

   // A write, or a one-cycle termination request that must still last four cycles.
   task automatic run_op(input int a, input int c, input bit dyn, input bit wr, input bit ch);
      int wl;
      int hi;
      wl = a + c;
      hi = wl - TERM_OFF_OFFSET_CK + ((wr && !ch) ? FULL_RETURN_CK : CHOP_RETURN_CK);
      @(posedge clk);
      al_in <= a[3:0];
      cwl_in <= c[3:0];
      dyn_in <= dyn;
      // A latency change re-reads the termination history, so older pulses drain first.
      repeat (29) @(posedge clk);
      #1;
      chk_bit("write_ready", 1'b1, wr_ready);
      @(posedge clk);
      wr_req <= wr;
      chop_in <= ch;
      odt_req <= !wr;
      @(posedge clk);
      wr_req <= 1'b0;
      odt_req <= 1'b0;
      for (int t = 1; t <= hi + 3; t++) begin
         @(posedge clk);
         #1;
         chk_bit("write_window", wr && t >= wl - 1 && t <= hi, win);
         chk_term("term_before_fall", exp_term(t - 1, wl - 1, hi, wr, dyn), term);
         #5;
         chk_term("term_after_fall", exp_term(t, wl - 1, hi, wr, dyn), term);
      end
   endtask : run_op

   task automatic run_level();
      int t;
      int k;
      @(posedge clk);
      lvl_start <= 1'b1;
      @(posedge clk);
      lvl_start <= 1'b0;
      // A write offered during leveling must be ignored.
      wr_req <= 1'b1;
      t = 0;
      k = 0;
      while (lvl_done !== 1'b1 && t < 60) begin
         @(posedge clk);
         wr_req <= 1'b0;
         #1;
         t++;
         if (t == 41) begin
            k = edge_n;
         end
         if (t == 20) begin
            chk_bit("level_busy", 1'b1, lvl_busy);
            chk_bit("level_mode", 1'b1, lvl_mode);
            chk_bit("level_ready", 1'b0, wr_ready);
         end
         chk_bit("window_in_level", 1'b0, win);
      end
      chk_bit("done_at_42", 1'b1, t == 42);
      chk_vec("level_result", {DQ_WIDTH{~k[0]}}, lvl_result);
      @(posedge clk);
      #1;
      chk_bit("done_pulse", 1'b0, lvl_done);
      chk_bit("strobe_early", 1'b0, strobe_early);
      chk_bit("odt_short", 1'b0, odt_short);
   endtask : run_level

   initial begin
      seed = 32'hC34DB7F9;
      error_cnt = 0;
      check_count = 0;
      nrst = 1'b0;
      al_in = 4'h0;
      cwl_in = 4'h5;
      dyn_in = 1'b0;
      odt_req = 1'b0;
      wr_req = 1'b0;
      chop_in = 1'b0;
      lvl_start = 1'b0;
      do_reset();
      run_op(0, 2, 1'b1, 1'b1, 1'b1);
      run_op(15, 15, 1'b1, 1'b1, 1'b0);
      run_op(3, 5, 1'b0, 1'b1, 1'b0);
      run_op(2, 4, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 10; i++) begin
         r = $random(seed);
         run_op(int'(r[1:0]), 2 + int'(r[4:2]), r[5], r[6], r[7]);
      end
      @(posedge clk);
      wr_req <= 1'b1;
      chop_in <= 1'b1;
      @(posedge clk);
      chop_in <= 1'b0;
      @(posedge clk);
      wr_req <= 1'b0;
      repeat (40) @(posedge clk);
      run_level();
      @(posedge clk);
      lvl_start <= 1'b1;
      @(posedge clk);
      lvl_start <= 1'b0;
      repeat (20) @(posedge clk);
      do_reset();
      run_level();
      report_and_stop();
   end

   // The tests need under 2000 cycles; 10000 leaves ample margin.
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
